// *** blfbc_pkg.sv ***
`default_nettype none
package blfbc_pkg;
    // ------------------------------------------------------------
    // register map and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SINK_EN    = 8'h00;
    localparam logic [7:0] ADDR_MAIN_CODE  = 8'h01;
    localparam logic [7:0] ADDR_SUB_CODE   = 8'h02;
    localparam logic [7:0] ADDR_FADE       = 8'h09;
    localparam logic [7:0] ADDR_ASSIGN     = 8'h0A;
    localparam logic [7:0] RST_SINK_EN     = 8'h00;
    localparam logic [7:0] RST_CODE        = 8'h00;
    localparam logic [7:0] RST_FADE        = 8'h00;
    localparam logic [7:0] RST_ASSIGN      = 8'h00;
    localparam int         FADE_EN_MAIN    = 3;
    localparam int         FADE_EN_SUB     = 0;
    localparam int         RATE_MAIN_LSB   = 4;
    localparam int         RATE_SUB_LSB    = 1;
    localparam int         RATE_W          = 2;
    localparam int         ASSIGN_W        = 3;
    // ------------------------------------------------------------
    // current code ladder
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_FIRST      = 8'h04;  // 0.5 mA
    localparam logic [7:0] CODE_LAST       = 8'h1F;  // 25 mA
    localparam logic [4:0] LVL_MAX         = 5'h1C;  // 28 steps above off
    localparam int         LVL_FINE_TOP    = 10;     // 5 mA
    localparam int         LVL_MID_TOP     = 26;     // 21 mA
    localparam int         HALF_MID_TOP    = 42;     // 21 mA in half mA
    localparam int         STEP_MID        = 2;      // 1 mA in half mA
    localparam int         STEP_HIGH       = 4;      // 2 mA in half mA
    localparam logic [5:0] HALF_LOW_BIAS   = 6'h08;  // 4.0 mA
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_PS   = 5000;
    localparam int         FADE_BASE_US    = 1000;
    localparam int         FADE_BASE_CYC   = FADE_BASE_US * 1000000 / CLK_PERIOD_PS;
    localparam int         PUMP_FREQ_KHZ   = 250;
    localparam int         PUMP_HALF_CYC   = 1000000000 / (PUMP_FREQ_KHZ * 2 * CLK_PERIOD_PS);
    localparam int         HYST_US         = 10;
    localparam int         HYST_CYC        = HYST_US * 1000000 / CLK_PERIOD_PS;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CP_1X  = 3'b001,
        CP_15X = 3'b010,
        CP_2X  = 3'b100
    } blfbc_cp_mode_t;
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } blfbc_wr_t;
    typedef logic [5:0] blfbc_half_ma_t;
endpackage : blfbc_pkg
`default_nettype wire

// *** blfbc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module blfbc_top
    import blfbc_pkg::*;
#(
    parameter int SINKS     = 6,
    parameter int FADE_BASE = FADE_BASE_CYC
) (
    // clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_i,
    // decoded register port from the single-wire receiver
    input  wire blfbc_wr_t                  wr_i,
    input  wire logic [7:0]                 rd_addr_i,
    output var  logic [7:0]                 rd_data_o,
    // pin-level inputs, asynchronous
    input  wire logic                       shutdown_i,
    input  wire logic                       demand_up_i,
    input  wire logic                       demand_down_i,
    // analog control
    output var  blfbc_half_ma_t [SINKS-1:0] sink_level_o,
    output var  logic                       low_bias_o,
    output var  logic                       sleep_o,
    output var  blfbc_cp_mode_t             cp_mode_o,
    output var  logic                       cp_clk_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // code to ladder index; codes under 04h are all off
    function automatic logic [4:0] code_to_lvl(input logic [7:0] code);
        if (code < CODE_FIRST) begin
            return '0;
        end else if (code > CODE_LAST) begin
            return LVL_MAX;
        end
        return 5'(code - CODE_FIRST + 8'h01);
    endfunction : code_to_lvl

    // ladder index to current in half mA
    function automatic blfbc_half_ma_t lvl_to_half(input logic [4:0] lvl);
        int i;
        i = int'(lvl);
        if (i <= LVL_FINE_TOP) begin
            return 6'(i);
        end else if (i <= LVL_MID_TOP) begin
            return 6'(LVL_FINE_TOP + STEP_MID * (i - LVL_FINE_TOP));
        end
        return 6'(HALF_MID_TOP + STEP_HIGH * (i - LVL_MID_TOP));
    endfunction : lvl_to_half

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       shut_s;
    logic       up_s;
    logic       down_s;

    // two flops per pin, only the second one is read
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {shutdown_i, demand_up_i, demand_down_i};
            sync2_reg <= sync1_reg;
        end
    end
    assign shut_s = sync2_reg[2];
    assign up_s   = sync2_reg[1];
    assign down_s = sync2_reg[0];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [7:0] sink_en_reg;
    logic [7:0] code_reg [2];
    logic [7:0] fade_reg;
    logic [7:0] assign_reg;
    logic       clr_cfg;

    assign clr_cfg = rst_i || shut_s;

    // writes land one cycle after the strobe; unmapped addresses drop
    always_ff @(posedge sys_clk_i) begin
        if (clr_cfg) begin
            sink_en_reg <= RST_SINK_EN;
            code_reg[0] <= RST_CODE;
            code_reg[1] <= RST_CODE;
            fade_reg    <= RST_FADE;
            assign_reg  <= RST_ASSIGN;
        end else if (wr_i.en) begin
            case (wr_i.addr)
                ADDR_SINK_EN:   sink_en_reg <= wr_i.data;
                ADDR_MAIN_CODE: code_reg[0] <= wr_i.data;
                ADDR_SUB_CODE:  code_reg[1] <= wr_i.data;
                ADDR_FADE:      fade_reg    <= wr_i.data;
                ADDR_ASSIGN:    assign_reg  <= wr_i.data;
                default: ;
            endcase
        end
    end

    // read back; unmapped offsets read zero
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            case (rd_addr_i)
                ADDR_SINK_EN:   rd_data_o <= sink_en_reg;
                ADDR_MAIN_CODE: rd_data_o <= code_reg[0];
                ADDR_SUB_CODE:  rd_data_o <= code_reg[1];
                ADDR_FADE:      rd_data_o <= fade_reg;
                ADDR_ASSIGN:    rd_data_o <= assign_reg;
                default:        rd_data_o <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // fade engines, one per bank
    // ------------------------------------------------------------
    logic [4:0]        lvl_reg  [2];
    logic [4:0]        tgt      [2];
    logic              fade_on  [2];
    logic [RATE_W-1:0] rate     [2];
    logic [RATE_W-1:0] tick_reg [2];
    logic [31:0]       base_reg;
    logic              base_tick;

    assign fade_on[0] = fade_reg[FADE_EN_MAIN];
    assign fade_on[1] = fade_reg[FADE_EN_SUB];
    assign rate[0]    = fade_reg[RATE_MAIN_LSB +: RATE_W];
    assign rate[1]    = fade_reg[RATE_SUB_LSB +: RATE_W];
    assign tgt[0]     = code_to_lvl(code_reg[0]);
    assign tgt[1]     = code_to_lvl(code_reg[1]);
    assign base_tick  = (base_reg == 32'(FADE_BASE - 1));

    // shared base timer; one tick per base interval
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || base_tick) begin
            base_reg <= '0;
        end else begin
            base_reg <= base_reg + 32'h0000_0001;
        end
    end

    // each step waits (rate + 1) base ticks, then moves one code
    always_ff @(posedge sys_clk_i) begin
        for (int b = 0; b < 2; b++) begin
            if (clr_cfg) begin
                lvl_reg[b]  <= '0;
                tick_reg[b] <= '0;
            end else if (!fade_on[b]) begin
                lvl_reg[b]  <= tgt[b];
                tick_reg[b] <= '0;
            end else if (lvl_reg[b] == tgt[b]) begin
                tick_reg[b] <= '0;
            end else if (base_tick) begin
                if (tick_reg[b] >= rate[b]) begin
                    tick_reg[b] <= '0;
                    // retarget works from the present level
                    if (lvl_reg[b] < tgt[b]) begin
                        lvl_reg[b] <= lvl_reg[b] + 5'h01;
                    end else begin
                        lvl_reg[b] <= lvl_reg[b] - 5'h01;
                    end
                end else begin
                    tick_reg[b] <= tick_reg[b] + 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sink outputs and bank assignment
    // ------------------------------------------------------------
    logic [ASSIGN_W-1:0] main_cnt;
    logic [ASSIGN_W-1:0] asg;
    blfbc_half_ma_t      half [2];
    logic                any_on;
    logic                low_bias;

    // zero and out-of-range field values keep all drivers in main
    assign asg      = assign_reg[ASSIGN_W-1:0];
    assign main_cnt = (asg == '0 || int'(asg) > SINKS) ? ASSIGN_W'(SINKS) : asg;
    assign half[0]  = lvl_to_half(lvl_reg[0]);
    assign half[1]  = lvl_to_half(lvl_reg[1]);

    always_ff @(posedge sys_clk_i) begin
        for (int s = 0; s < SINKS; s++) begin
            if (clr_cfg || !sink_en_reg[s]) begin
                sink_level_o[s] <= '0;
            end else if (s < int'(main_cnt)) begin
                sink_level_o[s] <= half[0];
            end else begin
                sink_level_o[s] <= half[1];
            end
        end
    end

    // bias and sleep look at what actually drives a sink
    always_comb begin
        any_on   = 1'b0;
        low_bias = 1'b1;
        for (int s = 0; s < SINKS; s++) begin
            if (sink_level_o[s] != '0) begin
                any_on = 1'b1;
            end
            if (sink_level_o[s] > HALF_LOW_BIAS) begin
                low_bias = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            low_bias_o <= 1'b1;
            sleep_o    <= 1'b1;
        end else begin
            low_bias_o <= low_bias;
            sleep_o    <= !any_on;
        end
    end

    // ------------------------------------------------------------
    // charge pump mode and switching clock
    // ------------------------------------------------------------
    logic [15:0] hyst_reg;
    logic [15:0] div_reg;

    // a demand must persist a full hysteresis window before a change, except that a direct
    // up/down reversal carries the running count over; the window keeps the mode from chattering on ripple
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || sleep_o) begin
            cp_mode_o <= CP_1X;
            hyst_reg  <= '0;
        end else if (up_s == down_s) begin
            hyst_reg  <= '0;
        end else if (hyst_reg != 16'(HYST_CYC - 1)) begin
            hyst_reg  <= hyst_reg + 16'h0001;
        end else begin
            hyst_reg  <= '0;
            case (cp_mode_o)
                CP_1X:   cp_mode_o <= up_s ? CP_15X : CP_1X;
                CP_15X:  cp_mode_o <= up_s ? CP_2X : CP_1X;
                CP_2X:   cp_mode_o <= up_s ? CP_2X : CP_15X;
                default: cp_mode_o <= CP_1X;
            endcase
        end
    end

    // 250 kHz square wave; frozen low in 1x to save switching loss
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || cp_mode_o == CP_1X) begin
            div_reg  <= '0;
            cp_clk_o <= 1'b0;
        end else if (div_reg == 16'(PUMP_HALF_CYC - 1)) begin
            div_reg  <= '0;
            cp_clk_o <= !cp_clk_o;
        end else begin
            div_reg  <= div_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    reset_all_off_a: assert property (@(posedge sys_clk_i)
        rst_i |=> (sink_level_o == '0))
        else $error("sinks not off after reset");

    disabled_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !sink_en_reg[0] |=> (sink_level_o[0] == '0))
        else $error("disabled sink still driven");

    zero_code_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (code_reg[0] == RST_CODE && !fade_on[0]) |=> (lvl_reg[0] == '0 && half[0] == '0))
        else $error("code zero not off");

    fade_one_step_a: assert property (@(posedge sys_clk_i) disable iff (clr_cfg)
        fade_on[0] && $past(fade_on[0]) |->
            (lvl_reg[0] - $past(lvl_reg[0]) <= 5'h01 || $past(lvl_reg[0]) - lvl_reg[0] <= 5'h01))
        else $error("fade skipped a code");

    fade_hold_a: assert property (@(posedge sys_clk_i) disable iff (clr_cfg)
        (fade_on[1] && lvl_reg[1] != tgt[1] && !base_tick) |=> $stable(lvl_reg[1]))
        else $error("fade moved without a tick");

    default_main_a: assert property (@(posedge sys_clk_i) disable iff (clr_cfg)
        (asg == '0 && sink_en_reg[SINKS-1]) |=> (sink_level_o[SINKS-1] == $past(half[0])))
        else $error("default bank not main");

    low_bias_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sink_level_o[0] > HALF_LOW_BIAS) |=> !low_bias_o)
        else $error("bias low at high current");

    sleep_pump_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sleep_o |=> (cp_mode_o == CP_1X) ##1 !cp_clk_o)
        else $error("pump running in sleep");

    pump_still_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (cp_mode_o == CP_1X) [*2] |-> !cp_clk_o)
        else $error("pump switching in 1x");

    ladder_top_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (lvl_reg[0] == LVL_MAX) |-> (half[0] == 6'(HALF_MID_TOP + 2 * STEP_HIGH)))
        else $error("top level not 25 mA");

endmodule : blfbc_top
`default_nettype wire

// *** blfbc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// host model: drives decoded register writes
// ------------------------------------------------------------
module blfbc_host
    import blfbc_pkg::*;
(
    // clock
    input  wire logic      sys_clk_i,
    // write port toward the device
    output var  blfbc_wr_t wr_o
);
    // idle port shows the inverse of the last write, so stale data never looks valid
    initial begin
        wr_o = '0;
    end
    // one write: en high for exactly one cycle, launched on the falling edge
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk_i);
        wr_o = '{en: 1'b1, addr: addr, data: data};
        @(negedge sys_clk_i);
        wr_o = '{en: 1'b0, addr: ~addr, data: ~data};
    endtask : write
    // fade-in from the 0.5 mA seed, main bank only
    task automatic fade_in(input logic [7:0] fade, input logic [7:0] en, input logic [7:0] code);
        write(ADDR_FADE, fade & 8'h36);        // fade enables cleared first
        write(ADDR_MAIN_CODE, CODE_FIRST);     // seed 0.5 mA
        write(ADDR_FADE, fade);
        write(ADDR_SINK_EN, en & 8'h3F);       // only the six connected sinks, bits 5:0
        write(ADDR_MAIN_CODE, code);           // target 05h..1Fh
    endtask : fade_in
endmodule : blfbc_host
`default_nettype wire

// *** blfbc_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module blfbc_top_tb import blfbc_pkg::*;;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    localparam int         FB    = 8;
    localparam int         LIMIT = 40000;
    localparam logic [7:0] ADDRS [6] = '{8'h00, 8'h01, 8'h02, 8'h09, 8'h0A, 8'h05};
    logic                  sys_clk_i, rst_i, shutdown_i, demand_up_i, demand_down_i;
    blfbc_wr_t             wr;
    logic [7:0]            rd_addr_i, rd_data_o, en_m, main_m, sub_m, asg_m;
    blfbc_half_ma_t [5:0]  sink_level_o;
    logic                  low_bias_o, sleep_o, cp_clk_o;
    blfbc_cp_mode_t        cp_mode_o;
    logic [15:0]           rnd;
    int                    n_errors, checks_done, k;
    int                    cycles = 0;
    // device and host
    blfbc_top #(.SINKS(6), .FADE_BASE(FB)) blfbc_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_i(wr),
        .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .shutdown_i(shutdown_i), .demand_up_i(demand_up_i),
        .demand_down_i(demand_down_i), .sink_level_o(sink_level_o), .low_bias_o(low_bias_o),
        .sleep_o(sleep_o), .cp_mode_o(cp_mode_o), .cp_clk_o(cp_clk_o));
    blfbc_host host_i (.sys_clk_i(sys_clk_i), .wr_o(wr));
    // 200 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // ------------------------------------------------------------
    // reference model and helpers
    // ------------------------------------------------------------
    function automatic int half_lvl(input int l);
        if (l <= 10) return l;                 // 0.5 mA steps
        if (l <= 26) return 2 * l - 10;        // 1 mA steps
        return 4 * l - 62;                     // 2 mA steps up to 25 mA
    endfunction : half_lvl
    function automatic int code_lvl(input int c);
        return (c < 4) ? 0 : ((c > 31) ? 28 : c - 3);  // 00h is off
    endfunction : code_lvl
    function automatic int lvl_of(input int h);
        for (int l = 0; l <= 28; l++) if (half_lvl(l) == h) return l;
        return -1;
    endfunction : lvl_of
    function automatic logic [15:0] lfsr(input logic [15:0] r);
        return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    endfunction : lfsr
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    // write through the host and track it in the model
    task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
        host_i.write(a, d);
        case (a)
            ADDR_SINK_EN:   en_m = d;
            ADDR_MAIN_CODE: main_m = d;
            ADDR_SUB_CODE:  sub_m = d;
            ADDR_ASSIGN:    asg_m = d;
            default: ;
        endcase
    endtask : wr_m
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk_i);
        rd_addr_i = a;
        @(negedge sys_clk_i);
        check("rd_data", 16'(rd_data_o), 16'(exp));
    endtask : rd_check
    // settled comparison of every sink against the model
    task automatic expect_all();
        int n, mx, h;
        n = (asg_m[2:0] == 3'd0 || asg_m[2:0] > 3'd6) ? 6 : int'(asg_m[2:0]);
        mx = 0;
        repeat (4) @(negedge sys_clk_i);
        for (int s = 0; s < 6; s++) begin
            h = en_m[s] ? half_lvl(code_lvl(s < n ? main_m : sub_m)) : 0;
            mx = (h > mx) ? h : mx;
            check("sink_level", 16'(sink_level_o[s]), 16'(h));
        end
        check("low_bias", 16'(low_bias_o), 16'(mx <= 8));
        check("sleep", 16'(sleep_o), 16'(mx == 0));
    endtask : expect_all
    // follow a fade on sink 0: adjacent codes only, fixed spacing
    task automatic fade_watch(input int tgt, input int per);
        int cur, gap, steps;
        cur = lvl_of(int'(sink_level_o[0]));
        gap = 0;
        steps = 0;
        for (int n = 0; n < 40 * per && cur != tgt; n++) begin
            @(negedge sys_clk_i);
            gap++;
            if (lvl_of(int'(sink_level_o[0])) != cur) begin
                cur += (tgt > cur) ? 1 : -1;
                check("fade_step", 16'(sink_level_o[0]), 16'(half_lvl(cur)));
                if (steps > 0) check("fade_gap", 16'(gap), 16'(per));
                gap = 0;
                steps++;
            end
        end
        check("fade_end", 16'(sink_level_o[0]), 16'(half_lvl(tgt)));
    endtask : fade_watch
    task automatic pump_wait(input blfbc_cp_mode_t m, input bit hold);
        int n;
        blfbc_cp_mode_t was;
        was = cp_mode_o;
        for (n = 0; n < 2200 && cp_mode_o === was; n++) @(negedge sys_clk_i);
        check("cp_mode", 16'(cp_mode_o), 16'(m));
        if (hold) check("cp_hyst", 16'(n >= 1990), 16'd1);
    endtask : pump_wait
    // hang guard: a stuck run still ends in the report
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            results();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, shutdown_i, demand_up_i, demand_down_i} = 4'b1000;
        {rd_addr_i, en_m, main_m, sub_m, asg_m} = '0;
        rnd = 16'hAF7D;
        repeat (4) @(negedge sys_clk_i);
        rst_i = 1'b0;
        expect_all(); // sinks off after power-up
        check("cp_mode", 16'(cp_mode_o), 16'(CP_1X));
        for (int i = 0; i < 6; i++) rd_check(ADDRS[i], 8'h00); // defaults, unmapped reads 0
        // full code sweep, default assignment puts all sinks on main
        wr_m(ADDR_SINK_EN, 8'h3F);
        for (int c = 0; c < 34; c++) begin
            wr_m(ADDR_MAIN_CODE, 8'(c));
            expect_all();
        end
        // every bank split with random codes and enables
        for (int a = 0; a < 8; a++) begin
            rnd = lfsr(rnd);
            wr_m(ADDR_ASSIGN, 8'(a));
            wr_m(ADDR_MAIN_CODE, {3'b0, rnd[4:0]});
            wr_m(ADDR_SUB_CODE, {3'b0, rnd[12:8]});
            wr_m(ADDR_SINK_EN, {2'b0, rnd[15:10]});
            expect_all();
            rd_check(ADDR_SUB_CODE, sub_m);
        end
        // fade-in on a three-sink main bank, sub code set to 00h (off)
        wr_m(ADDR_ASSIGN, 8'h03);
        wr_m(ADDR_SUB_CODE, 8'h00);
        host_i.fade_in(8'h08, 8'h07, 8'h0D);
        {en_m, main_m} = {8'h07, 8'h0D};
        fade_watch(10, FB);
        wr_m(ADDR_SINK_EN, 8'h3F);
        wr_m(ADDR_SUB_CODE, 8'h10);
        expect_all(); // sub applies at once; main fade is already done and sub has no fade enable
        wr_m(ADDR_FADE, 8'h19);
        wr_m(ADDR_MAIN_CODE, 8'h1F);
        fade_watch(28, 2 * FB);
        wr_m(ADDR_MAIN_CODE, 8'h00);
        for (int n = 0; n < 400 && lvl_of(int'(sink_level_o[0])) != 20; n++) @(negedge sys_clk_i);
        wr_m(ADDR_MAIN_CODE, 8'h1A);
        fade_watch(23, 2 * FB); // reversal mid-fade
        wr_m(ADDR_MAIN_CODE, 8'h00);
        fade_watch(0, 2 * FB);
        // sub bank fades down on its own engine; its sinks stay lit so the pump stays awake
        wr_m(ADDR_SUB_CODE, 8'h04);
        repeat (200) @(negedge sys_clk_i);
        expect_all();
        // pump steps with demand, clock only outside 1x
        demand_up_i = 1'b1;
        pump_wait(CP_15X, 1'b1);
        pump_wait(CP_2X, 1'b0);
        for (k = 0; k < 1000 && cp_clk_o === 1'b1; k++) @(negedge sys_clk_i);
        for (k = 0; k < 1000 && cp_clk_o !== 1'b1; k++) @(negedge sys_clk_i);
        for (k = 0; k < 1000 && cp_clk_o === 1'b1; k++) @(negedge sys_clk_i);
        check("cp_half", 16'(k), 16'(PUMP_HALF_CYC));
        {demand_up_i, demand_down_i} = 2'b01;
        pump_wait(CP_15X, 1'b0);
        demand_up_i = 1'b1;
        repeat (2500) @(negedge sys_clk_i);
        check("cp_mode", 16'(cp_mode_o), 16'(CP_15X)); // both demands hold the mode
        {demand_up_i, demand_down_i} = 2'b00;
        wr_m(ADDR_SINK_EN, 8'h00);
        expect_all();
        check("cp_mode", 16'(cp_mode_o), 16'(CP_1X));
        check("cp_clk", 16'(cp_clk_o), 16'd0);
        // shutdown returns everything to defaults
        wr_m(ADDR_SINK_EN, 8'h3F);
        wr_m(ADDR_MAIN_CODE, 8'h1F);
        shutdown_i = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        shutdown_i = 1'b0;
        {en_m, main_m, sub_m, asg_m} = '0;
        expect_all();
        for (int i = 0; i < 6; i++) rd_check(ADDRS[i], 8'h00);
        results();
    end
endmodule : blfbc_top_tb
`default_nettype wire
